// file: hw/modbus_map.svh
// Constants of the parameter access slave: codes, limits, timing.
// Assumes a 100 MHz clock and an RS485 transceiver on the UART pins.
`ifndef MODBUS_MAP_SVH
`define MODBUS_MAP_SVH

`define CLK_HZ       100000000
`define BAUD         9600
`define BIT_CYC      (`CLK_HZ / `BAUD)
// 3.5 characters of 11 bits, rounded up
`define GAP_TENTHS   385
`define GAP_CYC      ((`CLK_HZ / `BAUD) * `GAP_TENTHS / 10 + 1)

`define FN_RD_HOLD   8'h03
`define FN_RD_INPUT  8'h04
`define FN_WR_ONE    8'h06
`define FN_EXC_BIT   8'h80
`define EX_FUNC      8'h01
`define EX_ADDR      8'h02
`define EX_VAL       8'h03

`define MAP_FIRST    16'h0100
`define MAP_LAST     16'h0112
`define PARAM_NUM    19
`define QTY_MAX      16'h007d
`define PARAM_LIMIT  16'h03e8
`define RD_BYTES     8'h02

`define REQ_LEN      8
`define MIN_LEN      8'h04
`define TXB_LEN      6
`define LEN_EXC      3'h3
`define LEN_RD       3'h5
`define LEN_ECHO     3'h6
`define CRC_INIT     16'hffff
`define CRC_POLY     16'ha001

`endif

// file: hw/modbus_pkg.sv
// Types shared by the parameter access slave.
// Assumes the map header is compiled alongside.
`default_nettype none

package modbus_pkg;

  typedef enum logic [3:0] {
    S_IDLE = 4'b0001,
    S_EVAL = 4'b0010,
    S_SEND = 4'b0100,
    S_WAIT = 4'b1000
  } state_e;

  typedef struct packed {
    logic [7:0]  slave;
    logic [7:0]  func;
    logic [15:0] regaddr;
    logic [15:0] value;
  } req_s;

  typedef struct packed {
    logic        we;
    logic [4:0]  idx;
    logic [15:0] val;
  } param_wr_s;

endpackage : modbus_pkg

`default_nettype wire

// file: hw/modbus_uart.sv
// 8N1 UART receiver and transmitter for the RS485 link.
// Assumes the receive pin is asynchronous; transmit is same-clock.
`include "modbus_map.svh"
`default_nettype none

module modbus_uart #(
  parameter int unsigned BIT_CYC = `BIT_CYC
) (
  input  wire logic       i_clk,
  input  wire logic       i_reset_n,
  input  wire logic       i_rxd,
  input  wire logic       i_tx_start,
  input  wire logic [7:0] i_tx_byte,
  output logic            o_rx_valid,
  output logic [7:0]      o_rx_byte,
  output logic            o_tx_busy,
  output logic            o_txd
);
  localparam int CW = $clog2(BIT_CYC + 1);

  logic          sync1_r, sync2_r;
  logic          ract_r, ract_nxt;
  logic [CW-1:0] rcnt_r, rcnt_nxt;
  logic [3:0]    rbit_r, rbit_nxt;
  logic [7:0]    rsh_r, rsh_nxt;
  logic          rval_r, rval_nxt;
  logic          busy_r, busy_nxt;
  logic [CW-1:0] tcnt_r, tcnt_nxt;
  logic [3:0]    tbit_r, tbit_nxt;
  logic [9:0]    tsh_r, tsh_nxt;
  logic          txd_r, txd_nxt;

  // Start bit checked again at mid-bit to reject glitches
  always_comb begin
    ract_nxt = ract_r;
    rcnt_nxt = rcnt_r;
    rbit_nxt = rbit_r;
    rsh_nxt  = rsh_r;
    rval_nxt = 1'b0;
    if (!ract_r) begin
      if (!sync2_r) begin
        ract_nxt = 1'b1;
        rcnt_nxt = CW'(BIT_CYC / 2);
        rbit_nxt = 4'h0;
      end
    end else if (rcnt_r != '0) begin
      rcnt_nxt = rcnt_r - CW'(1);
    end else begin
      rcnt_nxt = CW'(BIT_CYC - 1);
      rbit_nxt = rbit_r + 4'h1;
      if (rbit_r == 4'h0) begin
        if (sync2_r) ract_nxt = 1'b0;
      end else if (rbit_r <= 4'h8) begin
        rsh_nxt = {sync2_r, rsh_r[7:1]};
      end else begin
        ract_nxt = 1'b0;
        rval_nxt = sync2_r;
      end
    end
  end

  always_comb begin
    busy_nxt = busy_r;
    tcnt_nxt = tcnt_r;
    tbit_nxt = tbit_r;
    tsh_nxt  = tsh_r;
    if (!busy_r) begin
      if (i_tx_start) begin
        busy_nxt = 1'b1;
        tsh_nxt  = {1'b1, i_tx_byte, 1'b0};
        tcnt_nxt = CW'(BIT_CYC - 1);
        tbit_nxt = 4'h0;
      end
    end else if (tcnt_r != '0) begin
      tcnt_nxt = tcnt_r - CW'(1);
    end else if (tbit_r == 4'h9) begin
      busy_nxt = 1'b0;
    end else begin
      tsh_nxt  = {1'b1, tsh_r[9:1]};
      tbit_nxt = tbit_r + 4'h1;
      tcnt_nxt = CW'(BIT_CYC - 1);
    end
    txd_nxt = busy_nxt ? tsh_nxt[0] : 1'b1;
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      sync1_r <= 1'b1;
      sync2_r <= 1'b1;
      ract_r  <= 1'b0;
      rcnt_r  <= '0;
      rbit_r  <= 4'h0;
      rsh_r   <= 8'h00;
      rval_r  <= 1'b0;
      busy_r  <= 1'b0;
      tcnt_r  <= '0;
      tbit_r  <= 4'h0;
      tsh_r   <= 10'h3ff;
      txd_r   <= 1'b1;
    end else begin
      sync1_r <= i_rxd;
      sync2_r <= sync1_r;
      ract_r  <= ract_nxt;
      rcnt_r  <= rcnt_nxt;
      rbit_r  <= rbit_nxt;
      rsh_r   <= rsh_nxt;
      rval_r  <= rval_nxt;
      busy_r  <= busy_nxt;
      tcnt_r  <= tcnt_nxt;
      tbit_r  <= tbit_nxt;
      tsh_r   <= tsh_nxt;
      txd_r   <= txd_nxt;
    end
  end

  assign o_rx_valid = rval_r;
  assign o_rx_byte  = rsh_r;
  assign o_tx_busy  = busy_r;
  assign o_txd      = txd_r;

endmodule : modbus_uart

`default_nettype wire

// file: hw/modbus_param_access_slave.sv
// Modbus RTU slave serving the function parameter holding registers.
// Assumes a half-duplex RS485 transceiver; slave address and motor
// state come from same-clock logic.
`include "modbus_map.svh"
`default_nettype none

// Function
// - Parameters sit at 0x0100 to 0x0112 and are all read/write.
// - Function 03 reads one register and replies byte count 2 plus value.
// - A good function 06 write is answered by an exact echo.
// - A write refused for its data or while running answers 0x86 with exception 03.
// - An unsupported function code yields exception 01.
// - An address out of the map or overflowing it yields exception 02.
// - Data over the limit or written while running yields exception 03.
// - Exceptions carry address, function with top bit set, code and CRC.
// - Function 04 at 0x0180 answers 0x84 with exception 02.
// - Function 04 with a bad quantity answers 0x84 with exception 03.
// - Frames for another slave address are not answered.
// - The link runs 9600 baud 8N1 half duplex.
// - Only functions 03 and 06 are executed; others, and 04 reading one in-map register, give exception 01.
module modbus_param_access_slave #(
  parameter int unsigned BIT_CYC = `BIT_CYC,
  parameter int unsigned GAP_CYC = `GAP_CYC
) (
  input  wire logic                    i_clk,
  input  wire logic                    i_reset_n,
  input  wire logic                    i_rxd,
  input  wire logic [7:0]              i_slave_addr,
  input  wire logic                    i_motor_running,
  output logic                         o_txd,
  output logic                         o_tx_en,
  output modbus_pkg::param_wr_s        o_param
);
  localparam int GW = $clog2(GAP_CYC + 1);

  function automatic logic [15:0] crc_step(input logic [15:0] c,
                                           input logic [7:0]  d);
    logic [15:0] x;
    x = c ^ {8'h00, d};
    for (int i = 0; i < 8; i++) begin
      x = x[0] ? ((x >> 1) ^ `CRC_POLY) : (x >> 1);
    end
    return x;
  endfunction : crc_step

  modbus_pkg::state_e    st_r, st_nxt;
  logic [7:0]            rx_buf_r [`REQ_LEN];
  logic [7:0]            rx_buf_nxt [`REQ_LEN];
  logic [7:0]            rx_cnt_r, rx_cnt_nxt;
  logic [15:0]           crc_r, crc_nxt;
  logic [GW-1:0]         gap_r, gap_nxt;
  logic [7:0]            tx_buf_r [`TXB_LEN];
  logic [7:0]            tx_buf_nxt [`TXB_LEN];
  logic [2:0]            tx_len_r, tx_len_nxt;
  logic [2:0]            tx_idx_r, tx_idx_nxt;
  logic                  tx_en_r, tx_en_nxt;
  logic [15:0]           params_r [`PARAM_NUM];
  logic [15:0]           params_nxt [`PARAM_NUM];
  modbus_pkg::param_wr_s param_r, param_nxt;

  logic                  rx_valid;
  logic [7:0]            rx_byte;
  logic                  tx_busy;
  logic                  tx_start;
  logic [7:0]            tx_byte;
  logic                  uart_txd;
  modbus_pkg::req_s      req;
  logic                  is_rd, is_wr, len_ok, frame_ok, discard;
  logic                  in_map, range_ok, qty_ok;
  logic [16:0]           rd_last;
  logic [4:0]            idx;
  logic [7:0]            exc;

  modbus_uart #(
    .BIT_CYC   (BIT_CYC)
  ) u_uart (
    .i_clk     (i_clk),
    .i_reset_n (i_reset_n),
    .i_rxd     (i_rxd),
    .i_tx_start(tx_start),
    .i_tx_byte (tx_byte),
    .o_rx_valid(rx_valid),
    .o_rx_byte (rx_byte),
    .o_tx_busy (tx_busy),
    .o_txd     (uart_txd)
  );

  assign req = '{slave:   rx_buf_r[0],
                 func:    rx_buf_r[1],
                 regaddr: {rx_buf_r[2], rx_buf_r[3]},
                 value:   {rx_buf_r[4], rx_buf_r[5]}};

  assign is_rd    = req.func == `FN_RD_HOLD || req.func == `FN_RD_INPUT;
  assign is_wr    = req.func == `FN_WR_ONE;
  assign len_ok   = rx_cnt_r == 8'(`REQ_LEN);
  // address match and CRC residue of zero
  assign frame_ok = rx_cnt_r >= `MIN_LEN && crc_r == 16'h0000
                    && req.slave == i_slave_addr;
  // Known functions must be exactly one request frame long
  assign discard  = !frame_ok || ((is_rd || is_wr) && !len_ok);
  assign in_map   = req.regaddr >= `MAP_FIRST && req.regaddr <= `MAP_LAST;
  assign rd_last  = {1'b0, req.regaddr} + {1'b0, req.value} - 17'h00001;
  assign range_ok = in_map && rd_last <= {1'b0, `MAP_LAST};
  assign qty_ok   = req.value != 16'h0000 && req.value <= `QTY_MAX;
  assign idx      = 5'(req.regaddr - `MAP_FIRST);

  // Quantity checked before address, as for standard slaves
  always_comb begin
    exc = 8'h00;
    if (!is_rd && !is_wr) begin
      exc = `EX_FUNC;
    end else if (is_rd) begin
      if (!qty_ok) exc = `EX_VAL;
      else if (!range_ok) exc = `EX_ADDR;
      else if (req.value != 16'h0001) exc = `EX_VAL;
      else if (req.func == `FN_RD_INPUT) exc = `EX_FUNC;
    end else begin
      if (!in_map) exc = `EX_ADDR;
      // refused while running or over limit
      else if (i_motor_running || req.value > `PARAM_LIMIT) exc = `EX_VAL;
    end
  end

  // CRC low byte goes out first
  assign tx_byte = (tx_idx_r < tx_len_r) ? tx_buf_r[tx_idx_r]
                 : (tx_idx_r == tx_len_r) ? crc_r[7:0] : crc_r[15:8];

  always_comb begin
    st_nxt     = st_r;
    rx_buf_nxt = rx_buf_r;
    rx_cnt_nxt = rx_cnt_r;
    crc_nxt    = crc_r;
    gap_nxt    = gap_r;
    tx_buf_nxt = tx_buf_r;
    tx_len_nxt = tx_len_r;
    tx_idx_nxt = tx_idx_r;
    tx_en_nxt  = tx_en_r;
    params_nxt = params_r;
    param_nxt  = param_r;
    param_nxt.we = 1'b0;
    tx_start   = 1'b0;
    unique case (st_r)
      modbus_pkg::S_IDLE: begin
        if (rx_valid) begin
          if (rx_cnt_r < 8'(`REQ_LEN)) rx_buf_nxt[rx_cnt_r[2:0]] = rx_byte;
          if (rx_cnt_r != 8'hff) rx_cnt_nxt = rx_cnt_r + 8'h01;
          crc_nxt = crc_step(crc_r, rx_byte);
          gap_nxt = '0;
        end else if (rx_cnt_r != 8'h00) begin
          if (gap_r == GW'(GAP_CYC)) st_nxt = modbus_pkg::S_EVAL;
          else gap_nxt = gap_r + GW'(1);
        end
      end
      modbus_pkg::S_EVAL: begin
        rx_cnt_nxt = 8'h00;
        crc_nxt    = `CRC_INIT;
        gap_nxt    = '0;
        tx_idx_nxt = 3'h0;
        tx_buf_nxt[0] = req.slave;
        if (discard) begin
          st_nxt = modbus_pkg::S_IDLE;
        end else begin
          st_nxt    = modbus_pkg::S_SEND;
          tx_en_nxt = 1'b1;
          if (exc != 8'h00) begin
            tx_buf_nxt[1] = req.func | `FN_EXC_BIT;
            tx_buf_nxt[2] = exc;
            tx_len_nxt    = `LEN_EXC;
          end else if (is_rd) begin
            tx_buf_nxt[1] = req.func;
            tx_buf_nxt[2] = `RD_BYTES;
            tx_buf_nxt[3] = params_r[idx][15:8];
            tx_buf_nxt[4] = params_r[idx][7:0];
            tx_len_nxt    = `LEN_RD;
          end else begin
            for (int i = 1; i < `TXB_LEN; i++) tx_buf_nxt[i] = rx_buf_r[i];
            tx_len_nxt      = `LEN_ECHO;
            params_nxt[idx] = req.value;
            param_nxt       = '{we: 1'b1, idx: idx, val: req.value};
          end
        end
      end
      modbus_pkg::S_SEND: begin
        tx_start = 1'b1;
        if (tx_idx_r < tx_len_r) crc_nxt = crc_step(crc_r, tx_byte);
        st_nxt = modbus_pkg::S_WAIT;
      end
      modbus_pkg::S_WAIT: begin
        if (!tx_busy) begin
          if (tx_idx_r == tx_len_r + 3'h1) begin
            st_nxt    = modbus_pkg::S_IDLE;
            tx_en_nxt = 1'b0;
            crc_nxt   = `CRC_INIT;
          end else begin
            tx_idx_nxt = tx_idx_r + 3'h1;
            st_nxt     = modbus_pkg::S_SEND;
          end
        end
      end
      default: begin
        st_nxt    = modbus_pkg::S_IDLE;
        tx_en_nxt = 1'b0;
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      st_r     <= modbus_pkg::S_IDLE;
      rx_cnt_r <= 8'h00;
      crc_r    <= `CRC_INIT;
      gap_r    <= '0;
      tx_len_r <= 3'h0;
      tx_idx_r <= 3'h0;
      tx_en_r  <= 1'b0;
      param_r  <= '0;
      for (int i = 0; i < `REQ_LEN; i++) rx_buf_r[i] <= 8'h00;
      for (int i = 0; i < `TXB_LEN; i++) tx_buf_r[i] <= 8'h00;
      for (int i = 0; i < `PARAM_NUM; i++) params_r[i] <= 16'h0000;
    end else begin
      st_r     <= st_nxt;
      rx_buf_r <= rx_buf_nxt;
      rx_cnt_r <= rx_cnt_nxt;
      crc_r    <= crc_nxt;
      gap_r    <= gap_nxt;
      tx_buf_r <= tx_buf_nxt;
      tx_len_r <= tx_len_nxt;
      tx_idx_r <= tx_idx_nxt;
      tx_en_r  <= tx_en_nxt;
      params_r <= params_nxt;
      param_r  <= param_nxt;
    end
  end

  assign o_txd   = uart_txd;
  assign o_tx_en = tx_en_r;
  assign o_param = param_r;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);

  sequence s_eval_ok;
    st_r == modbus_pkg::S_EVAL && !discard;
  endsequence

  sequence s_reply_start;
    st_r == modbus_pkg::S_SEND && tx_en_r;
  endsequence

  a_param_store: assert property (
    s_eval_ok ##0 (exc == 8'h00 && is_wr) |=>
      o_param.we && o_param.val == $past(req.value))
    else $error("parameter write not stored");

  a_read_reply: assert property (
    s_eval_ok ##0 (exc == 8'h00 && is_rd) |=>
      s_reply_start ##0 (tx_len_r == `LEN_RD && tx_buf_r[2] == `RD_BYTES))
    else $error("read reply malformed");

  a_write_echo: assert property (
    s_eval_ok ##0 (exc == 8'h00 && is_wr) |=>
      tx_len_r == `LEN_ECHO && tx_buf_r[5] == $past(rx_buf_r[5]))
    else $error("write echo malformed");

  a_busy_refuse: assert property (
    s_eval_ok ##0 (is_wr && in_map && i_motor_running) |=>
      tx_buf_r[1] == (`FN_WR_ONE | `FN_EXC_BIT) && tx_buf_r[2] == `EX_VAL
      && !o_param.we)
    else $error("write while running not refused");

  a_bad_func: assert property (
    s_eval_ok ##0 (!is_rd && !is_wr) |=> tx_buf_r[2] == `EX_FUNC)
    else $error("unsupported function not flagged");

  a_bad_addr: assert property (
    s_eval_ok ##0 (is_rd && qty_ok && !range_ok) |=> tx_buf_r[2] == `EX_ADDR)
    else $error("bad address not flagged");

  a_qty_limit: assert property (
    s_eval_ok ##0 (is_rd && !qty_ok) |=> tx_buf_r[2] == `EX_VAL)
    else $error("bad quantity not flagged");

  a_exc_frame: assert property (
    s_eval_ok ##0 (exc != 8'h00) |=>
      tx_len_r == `LEN_EXC && tx_buf_r[1] == ($past(req.func) | `FN_EXC_BIT))
    else $error("exception frame malformed");

  a_drop_frame: assert property (
    st_r == modbus_pkg::S_EVAL && discard |=>
      st_r == modbus_pkg::S_IDLE && !o_tx_en [*2])
    else $error("bad frame answered");

  a_line_idle: assert property (
    !o_tx_en |-> o_txd)
    else $error("line driven low while released");

endmodule : modbus_param_access_slave

`default_nettype wire

// file: sim/modbus_master.sv
// Serial master model: sends request frames and collects replies.
// Assumes 8N1 at BIT_CYC clocks a bit; drives its line on falling edges.
`default_nettype none

module modbus_master #(
  parameter int unsigned BIT_CYC = 16
) (
  input  wire logic i_clk,
  input  wire logic i_txd,
  input  wire logic i_tx_en,
  output logic      o_rxd
);
  timeunit 1ns;
  timeprecision 1ns;

  typedef logic [7:0] bytes_t[$];

  // Line is biased high while the master is idle
  initial o_rxd = 1'b1;

  function automatic logic [15:0] crc16(input bytes_t f);
    logic [15:0] c;
    c = 16'hffff;
    foreach (f[i]) begin
      c = c ^ {8'h00, f[i]};
      repeat (8) c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
    end
    return c;
  endfunction : crc16

  // start bit, eight bits from the lowest, one stop bit
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] sh;
    sh = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(negedge i_clk) o_rxd = sh[i];
      repeat (BIT_CYC - 1) @(negedge i_clk);
    end
  endtask : send_byte

  // caller sets address and quantity; sum low byte first
  task automatic send_frame(input bytes_t f, input logic bad);
    logic [15:0] c;
    c = crc16(f) ^ {15'h0000, bad};
    f.push_back(c[7:0]);
    f.push_back(c[15:8]);
    foreach (f[i]) send_byte(f[i]);
  endtask : send_frame

  // reply bytes sampled mid-bit; a low stop bit spoils the byte
  task automatic get_reply(input int unsigned wait_cyc, output bytes_t r);
    logic [7:0]  b;
    int unsigned n;
    r = {};
    n = 0;
    while (i_tx_en !== 1'b1 && n < wait_cyc) begin
      @(posedge i_clk);
      n++;
    end
    while (i_tx_en === 1'b1) begin
      @(posedge i_clk);
      if (i_txd === 1'b0) begin
        repeat (BIT_CYC / 2) @(posedge i_clk);
        for (int i = 0; i < 8; i++) begin
          repeat (BIT_CYC) @(posedge i_clk);
          b[i] = i_txd;
        end
        repeat (BIT_CYC) @(posedge i_clk);
        r.push_back(i_txd === 1'b1 ? b : 8'hxx);
      end
    end
  endtask : get_reply

endmodule : modbus_master

`default_nettype wire

// file: sim/modbus_param_access_slave_tb.sv
// Self-checking bench for the parameter access slave.
// Assumes the master model on the link and a shortened bit time.
`default_nettype none

module modbus_param_access_slave_tb;
  timeunit 1ns;
  timeprecision 1ns;

  localparam int unsigned BIT_CYC = 16;
  localparam int unsigned GAP_CYC = 250;
  localparam int unsigned LIMIT   = 95000;
  typedef logic [7:0] bytes_t[$];

  logic                  i_clk = 1'b0;
  logic                  i_reset_n = 1'b0;
  logic                  i_motor_running = 1'b0;
  logic                  rxd;
  logic                  o_txd;
  logic                  o_tx_en;
  logic [7:0]            sa = 8'h01;
  modbus_pkg::param_wr_s o_param;
  logic [15:0]           mirror [19] = '{default: 16'h0000};
  bytes_t                q;
  bytes_t                none;
  logic [15:0]           v;
  logic [15:0]           wv;
  logic [4:0]            wi;
  int unsigned           n_errors = 0;
  int unsigned           total_checks = 0;
  int unsigned           n_we = 0;
  int unsigned           nw;
  int unsigned           cyc = 0;

  modbus_param_access_slave #(
    .BIT_CYC(BIT_CYC),
    .GAP_CYC(GAP_CYC)
  ) u_modbus_param_access_slave (
    .i_clk          (i_clk),
    .i_reset_n      (i_reset_n),
    .i_rxd          (rxd),
    .i_slave_addr   (sa),
    .i_motor_running(i_motor_running),
    .o_txd          (o_txd),
    .o_tx_en        (o_tx_en),
    .o_param        (o_param)
  );

  modbus_master #(.BIT_CYC(BIT_CYC)) u_modbus_master (
    .i_clk  (i_clk),
    .i_txd  (o_txd),
    .i_tx_en(o_tx_en),
    .o_rxd  (rxd)
  );

  always #5 i_clk = ~i_clk;

  task automatic report_and_stop;
    $display("checks %0d, mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : report_and_stop

  // Hang guard; also counts store pulses
  always @(posedge i_clk) begin
    cyc++;
    if (o_param.we === 1'b1) n_we++;
    if (cyc == LIMIT) begin
      n_errors++;
      report_and_stop();
    end
  end

  task automatic check(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : check

  function automatic bytes_t f6(input logic [7:0] fn, input logic [15:0] a,
                                input logic [15:0] d);
    return '{sa, fn, a[15:8], a[7:0], d[15:8], d[7:0]};
  endfunction : f6

  function automatic bytes_t exc(input logic [7:0] fn, input logic [7:0] c);
    return '{sa, fn | 8'h80, c};
  endfunction : exc

  // Expected reply gets its sum appended; empty means silence
  task automatic xact(input bytes_t req, input logic bad, input bytes_t exp);
    bytes_t      r;
    logic [15:0] c;
    u_modbus_master.send_frame(req, bad);
    u_modbus_master.get_reply(GAP_CYC + 100, r);
    if (exp.size() > 0) begin
      c = u_modbus_master.crc16(exp);
      exp.push_back(c[7:0]);
      exp.push_back(c[15:8]);
    end
    check("reply length", 16'(exp.size()), 16'(r.size()));
    foreach (exp[i])
      if (i < r.size()) check("reply byte", {8'h00, exp[i]}, {8'h00, r[i]});
  endtask : xact

  task automatic rd(input logic [4:0] i);
    v = mirror[i];
    xact(f6(8'h03, 16'h0100 + 16'(i), 16'h0001), 1'b0,
         '{sa, 8'h03, 8'h02, v[15:8], v[7:0]});
  endtask : rd

  task automatic wr(input logic [4:0] i, input logic [15:0] d);
    nw = n_we;
    q = f6(8'h06, 16'h0100 + 16'(i), d);
    xact(q, 1'b0, q);
    mirror[i] = d;
    check("store pulses", 16'(nw + 1), 16'(n_we));
    check("store index", 16'(i), 16'(o_param.idx));
    check("store value", d, o_param.val);
  endtask : wr

  task automatic xe(input logic [7:0] fn, input logic [15:0] a,
                    input logic [15:0] d, input logic [7:0] c);
    nw = n_we;
    xact(f6(fn, a, d), 1'b0, exc(fn, c));
    check("refused store", 16'(nw), 16'(n_we));
  endtask : xe

  initial begin
    void'($urandom(559));
    sa = 8'($urandom_range(247, 1));
    repeat (2) @(posedge i_clk);
    @(negedge i_clk) i_reset_n = 1'b1;
    repeat (3) @(posedge i_clk);
    check("idle link", 16'h0001, {14'h0000, o_tx_en, o_txd});
    check("idle store", 16'h0000, 16'({o_param.we, o_param.idx}));
    $display("test reset done");

    // Own index and value: rd and wr reuse v and nw
    for (int k = 0; k < 3; k++) begin
      wv = 16'($urandom_range(16'h03e8));
      wi = 5'($urandom_range(18));
      rd(wi);
      wr(wi, wv);
      rd(wi);
    end
    wr(5'd0, 16'h03e8);
    // Values over the limit are refused, so stay inside it
    wr(5'd18, 16'($urandom_range(16'h03e8)));
    rd(5'd18);
    $display("test read write done");

    xe(8'h06, 16'h0100, 16'h03e9, 8'h03);
    @(negedge i_clk) i_motor_running = 1'b1;
    xe(8'h06, 16'h0100, 16'h0001, 8'h03);
    rd(5'd0);
    @(negedge i_clk) i_motor_running = 1'b0;
    $display("test refused write done");

    xe(8'h06, 16'h0113, 16'h0001, 8'h02);
    xe(8'h03, 16'h00ff, 16'h0001, 8'h02);
    xe(8'h03, 16'h0112, 16'h0002, 8'h02);
    xe(8'h03, 16'h0100, 16'h0002, 8'h03);
    xe(8'h03, 16'h0100, 16'h0000, 8'h03);
    $display("test address done");

    q = '{8'h01, 8'h08, 8'h10, 8'h2b};
    foreach (q[i]) xe(q[i], 16'h0008, 16'h000d, 8'h01);
    xe(8'h04, 16'h0180, 16'h0007, 8'h02);
    xe(8'h04, 16'h0080, 16'h0180, 8'h03);
    xe(8'h04, 16'h0100, 16'h0001, 8'h01);
    $display("test function codes done");

    nw = n_we;
    q = f6(8'h06, 16'h0101, 16'h0005);
    q[0] = sa ^ 8'h80;
    xact(q, 1'b0, none);
    xact(f6(8'h06, 16'h0101, 16'h0005), 1'b1, none);
    check("dropped store", 16'(nw), 16'(n_we));
    rd(5'd1);
    $display("test dropped frames done");

    @(negedge i_clk) i_reset_n = 1'b0;
    repeat (2) @(negedge i_clk);
    i_reset_n = 1'b1;
    mirror = '{default: 16'h0000};
    repeat (3) @(posedge i_clk);
    check("reset link", 16'h0001, {14'h0000, o_tx_en, o_txd});
    check("reset store", 16'h0000, 16'({o_param.we, o_param.idx}));
    rd(wi);
    $display("test mid-run reset done");
    report_and_stop();
  end

endmodule : modbus_param_access_slave_tb

`default_nettype wire
